// [design/dpm_pkg.sv]
// Constants, types and register map of the dual-partition program map.
// What this block does
// R1: Each program word is 24 bits; even address lower word, odd upper.
// R2: Program counter stays even and steps by two up or down.
// R3: Addresses 000000h to 000200h are reserved for execution vectors.
// R4: Fetching starts at 000000h after reset; the jump target sits at 000002h.
// R5: Primary vector table is fixed at 000004h to 0000FFh.
// R6: Optional alternate vector table, enabled first, at a configurable base.
// R7: Three organisations: one single-partition and two dual-partition modes.
// R8: Dual modes split flash into two equal partitions; only active executes.
// R9: Active partition appears at 000000h, inactive at 400000h.
// R10: Write block is 64 words, erase block is 512 words.
// R11: At reset in dual mode, lower boot sequence number picks active.
// R12: Single-partition mode ignores the boot sequence words.
// R13: New boot sequence numbers act only at the next reset.
// R14: Equal or both corrupted boot numbers select partition 1.
// R15: With one corrupted boot number, the intact partition becomes active.
// R16: A swap instruction exchanges active and inactive at run time.
// R17: A run-time swap does not affect the choice at the next reset.
// R18: Control register bit 10 reads 1 when partition 2 is active.
// R19: Top nine program words are copied to configuration registers at reset.
// R20: Active partition's words configure the device in dual modes.
// R21: Inactive security, limit and signature words restrict access to it.
// R22: Unimplemented program regions read zero with no side effect.
package dpm_pkg;

    // ------------------------------------------------------------
    // Address map of program space
    // ------------------------------------------------------------
    localparam logic [23:0] RESET_ADDR   = 24'h000000;
    localparam logic [23:0] VEC_RSV_END  = 24'h000200;
    localparam logic [23:0] VTAB_BASE    = 24'h000004;
    localparam logic [23:0] VTAB_END     = 24'h0000FF;
    localparam logic [23:0] INACT_BASE   = 24'h400000;
    localparam logic [23:0] SINGLE_TOP   = 24'h02AFFE;
    localparam logic [23:0] DUAL_TOP     = 24'h0157FE;
    localparam int          CFG_WORDS    = 9;
    localparam logic [23:0] CFG_SPAN     = 24'h000010;
    localparam logic [11:0] WR_BLK_WORDS = 12'h040;
    localparam logic [11:0] ER_BLK_WORDS = 12'h200;

    // ------------------------------------------------------------
    // Configuration word slots and fields
    // ------------------------------------------------------------
    localparam logic [3:0] CFG_BSEQ   = 4'h0;
    localparam logic [3:0] CFG_SEC    = 4'h1;
    localparam logic [3:0] CFG_BSLIM  = 4'h2;
    localparam logic [3:0] CFG_SIGN   = 4'h3;
    localparam int         SEC_RDP    = 0;
    localparam int         SEC_LIMEN  = 1;
    localparam int         SIGN_OPEN  = 0;
    localparam int         P2_ACT_BIT = 10;

    // ------------------------------------------------------------
    // Register indices and reset values
    // ------------------------------------------------------------
    localparam logic [4:0]  REG_NVCTRL = 5'h00;
    localparam logic [4:0]  REG_AIVTB  = 5'h01;
    localparam logic [4:0]  REG_AIVTC  = 5'h02;
    localparam logic [4:0]  REG_GEOM   = 5'h03;
    localparam logic [4:0]  REG_STAT   = 5'h04;
    localparam logic [4:0]  REG_CFG0   = 5'h08;
    localparam logic [23:0] AIVT_RST   = 24'h000200;

    typedef enum logic [1:0] {
        DPM_SINGLE = 2'b00,
        DPM_DUAL_A = 2'b01,
        DPM_DUAL_B = 2'b10
    } dpm_mode_e;

    typedef enum logic [2:0] {
        ST_STRAP = 3'b000,
        ST_BSQ1  = 3'b001,
        ST_BSQ2  = 3'b010,
        ST_PICK  = 3'b011,
        ST_CFG   = 3'b100,
        ST_ICFG  = 3'b101,
        ST_RUN   = 3'b110
    } dpm_state_e;

    typedef enum logic [2:0] {
        PC_HOLD = 3'b000,
        PC_INC  = 3'b001,
        PC_DEC  = 3'b010,
        PC_LOAD = 3'b011,
        PC_VEC  = 3'b100
    } dpm_pc_op_e;

    typedef struct packed {
        logic        req;
        logic [23:0] addr;
    } dpm_fetch_req_s;

    typedef struct packed {
        logic        valid;
        logic        denied;
        logic [15:0] data;
    } dpm_fetch_rsp_s;

    typedef logic [CFG_WORDS-1:0][23:0] dpm_cfg_t;

endpackage : dpm_pkg

// [design/dpm_program_map.sv]
// Program memory map, partition selection, reset loader and program counter.
`timescale 1ns/1ns

module dpm_program_map #(
    parameter logic [23:0] S_TOP = dpm_pkg::SINGLE_TOP,  // Last single-mode word.
    parameter logic [23:0] D_TOP = dpm_pkg::DUAL_TOP     // Last word per partition.
) (
    input  wire logic                   clk,         // 100 MHz system clock.
    input  wire logic                   rst,         // Synchronous reset, high.
    input  wire logic [1:0]             mode_strap,  // Flash organisation strap.
    input  wire dpm_pkg::dpm_fetch_req_s fetch_req,  // CPU fetch or table read.
    output logic                        fetch_rdy,   // Fetch path open.
    output dpm_pkg::dpm_fetch_rsp_s     fetch_rsp,   // Read answer, two cycles after request.
    input  wire logic                   partition_swap_instruction, // Swap pulse.
    input  wire dpm_pkg::dpm_pc_op_e    pc_op,       // Program counter action.
    input  wire logic [23:0]            pc_target,   // Jump destination.
    input  wire logic [6:0]             vec_num,     // Vector to take.
    output logic [23:0]                 pc,          // Program counter.
    output logic                        pc_in_vectors, // PC in vector area.
    output logic                        fl_rd,       // Flash read strobe.
    output logic [23:0]                 fl_addr,     // Physical flash address.
    input  wire logic [23:0]            fl_rdata,    // Flash word, same cycle as strobe.
    output dpm_pkg::dpm_cfg_t           cfg,         // Configuration registers.
    output logic                        second_partition_active, // Status.
    input  wire logic [4:0]             reg_addr,    // Register index.
    input  wire logic [23:0]            reg_wdata,   // Register write data.
    input  wire logic                   reg_wr,      // Write strobe.
    input  wire logic                   reg_rd,      // Read strobe.
    output logic [23:0]                 reg_rdata    // Read data, cycle after.
);
    import dpm_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    dpm_state_e     st_q;
    dpm_mode_e      mode_q;
    logic [1:0]     ph_q;
    logic [3:0]     idx_q;
    logic [23:0]    bsq1_q, bsq2_q, isec_q, ilim_q, isig_q;
    logic [23:0]    aivt_base_q, pc_q, fl_addr_q, rdata_q;
    logic           p2_q, odd_q, zero_q, deny_q, pend_q;
    logic           aivt_en_q, prot_err_q, fallback_q, rdy_q, fl_rd_q;
    dpm_cfg_t       cfg_q;
    dpm_fetch_rsp_s rsp_q;

    logic           dual, bsq1_ok, bsq2_ok, pick_p2, f_inact, f_impl, f_deny;
    logic [23:0]    top, cfg_base, f_off, f_phys, boot_addr, vec_addr, vec_end;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    // Both dual encodings share one map.
    assign dual     = (mode_q != DPM_SINGLE);                         // see R7
    assign top      = dual ? D_TOP : S_TOP;
    assign cfg_base = top - CFG_SPAN;                                 // see R19

    // A boot number is intact when its upper half is the lower inverted.
    assign bsq1_ok = (bsq1_q[23:12] == ~bsq1_q[11:0]);
    assign bsq2_ok = (bsq2_q[23:12] == ~bsq2_q[11:0]);

    // Ties and double damage fall back to partition 1.
    always_comb begin
        if (!dual) begin
            pick_p2 = 1'b0;                                           // see R12
        end else if (bsq1_ok && bsq2_ok) begin
            pick_p2 = (bsq2_q[11:0] < bsq1_q[11:0]);          // see R11, R14
        end else begin
            pick_p2 = bsq2_ok && !bsq1_ok;                    // see R14, R15
        end
    end

    // Bit 22 picks the role, the active flag picks the physical half.
    assign f_inact = dual && fetch_req.addr[22];                      // see R9
    assign f_off   = {2'b00, fetch_req.addr[21:0]};
    assign f_impl  = !fetch_req.addr[23] && (dual ?
                     (f_off <= (top | 24'h000001)) :
                     (fetch_req.addr <= (top | 24'h000001)));        // see R22
    assign f_phys  = dual ? {1'b0, f_inact ^ p2_q, f_off[21:1], 1'b0}
                          : {fetch_req.addr[23:1], 1'b0};             // see R8

    // The inactive half may refuse reads from the running code.
    assign f_deny = f_inact && (
        (isec_q[SEC_RDP] && !isig_q[SIGN_OPEN]) ||
        (isec_q[SEC_LIMEN] && (f_off < ilim_q)));                     // see R21

    // Physical address of the current loader read.
    always_comb begin
        if (st_q == ST_BSQ1) begin
            boot_addr = cfg_base;
        end else if (st_q == ST_BSQ2) begin
            boot_addr = INACT_BASE | cfg_base;
        end else if (st_q == ST_CFG) begin
            boot_addr = {1'b0, dual & p2_q, cfg_base[21:0]}
                      + {19'h0, idx_q, 1'b0};                         // see R20
        end else begin
            boot_addr = {1'b0, !p2_q, cfg_base[21:0]}
                      + {19'h0, idx_q, 1'b0};
        end
    end

    // Vector slots are two addresses apart; the primary table never moves.
    assign vec_addr = (aivt_en_q ? aivt_base_q : VTAB_BASE)
                    + {16'h0, vec_num, 1'b0};                         // see R5, R6
    assign vec_end  = aivt_en_q ? (aivt_base_q + (VTAB_END - VTAB_BASE))
                                : VTAB_END;

    // ------------------------------------------------------------
    // Reset loader sequencer
    // ------------------------------------------------------------
    // Each flash read takes three phases: strobe, capture, settle. The boot
    // numbers are read only here, so rewriting them acts after a reset.
    always_ff @(posedge clk) begin
        if (rst) begin
            st_q  <= ST_STRAP;
            ph_q  <= 2'd0;
            idx_q <= 4'h0;
            rdy_q <= 1'b0;
        end else begin
            case (st_q)
                ST_STRAP: begin
                    st_q <= (mode_strap != DPM_SINGLE) ? ST_BSQ1 : ST_CFG;
                end
                ST_BSQ1: begin
                    ph_q <= (ph_q == 2'd2) ? 2'd0 : ph_q + 2'd1;
                    if (ph_q == 2'd2) begin
                        st_q <= ST_BSQ2;
                    end
                end
                ST_BSQ2: begin
                    ph_q <= (ph_q == 2'd2) ? 2'd0 : ph_q + 2'd1;
                    if (ph_q == 2'd2) begin
                        st_q <= ST_PICK;
                    end
                end
                ST_PICK: begin
                    st_q <= ST_CFG;
                end
                ST_CFG: begin
                    ph_q <= (ph_q == 2'd2) ? 2'd0 : ph_q + 2'd1;
                    if (ph_q == 2'd2) begin
                        idx_q <= idx_q + 4'h1;
                        if (idx_q == 4'(CFG_WORDS - 1)) begin
                            idx_q <= CFG_SEC;
                            st_q  <= dual ? ST_ICFG : ST_RUN;
                            rdy_q <= !dual;
                        end
                    end
                end
                ST_ICFG: begin
                    ph_q <= (ph_q == 2'd2) ? 2'd0 : ph_q + 2'd1;
                    if (ph_q == 2'd2) begin
                        idx_q <= idx_q + 4'h1;
                        if (idx_q == CFG_SIGN) begin
                            st_q <= ST_RUN;
                            rdy_q <= 1'b1;
                        end
                    end
                end
                default: begin
                    st_q <= ST_RUN;
                    rdy_q <= 1'b1;
                end
            endcase
        end
    end

    // The strap is caught in the first clocked cycle after reset release.
    always_ff @(posedge clk) begin
        if (rst) begin
            mode_q <= DPM_SINGLE;
        end else if (st_q == ST_STRAP) begin
            mode_q <= dpm_mode_e'(mode_strap);                        // see R7
        end
    end

    // Boot numbers and the inactive half's access words.
    always_ff @(posedge clk) begin
        if (rst) begin
            bsq1_q <= 24'h000000;
            bsq2_q <= 24'h000000;
            isec_q <= 24'h000000;
            ilim_q <= 24'h000000;
            isig_q <= 24'h000000;
        end else if (ph_q == 2'd1) begin
            if (st_q == ST_BSQ1) begin
                bsq1_q <= fl_rdata;                                   // see R13
            end
            if (st_q == ST_BSQ2) begin
                bsq2_q <= fl_rdata;
            end
            if (st_q == ST_ICFG && idx_q == CFG_SEC) begin
                isec_q <= fl_rdata;                                   // see R21
            end
            if (st_q == ST_ICFG && idx_q == CFG_BSLIM) begin
                ilim_q <= fl_rdata;
            end
            if (st_q == ST_ICFG && idx_q == CFG_SIGN) begin
                isig_q <= fl_rdata;
            end
        end
    end

    // Configuration registers follow the active half's top words.
    always_ff @(posedge clk) begin
        if (rst) begin
            cfg_q <= '0;
        end else if (st_q == ST_CFG && ph_q == 2'd1) begin
            cfg_q[idx_q] <= fl_rdata;                             // see R19, R20
        end
    end

    // ------------------------------------------------------------
    // Active partition flag
    // ------------------------------------------------------------
    // Chosen once per reset; a swap toggles only this live flag.
    always_ff @(posedge clk) begin
        if (rst) begin
            p2_q       <= 1'b0;
            fallback_q <= 1'b0;
        end else if (st_q == ST_PICK) begin
            p2_q       <= pick_p2;                                    // see R11
            fallback_q <= !(bsq1_ok && bsq2_ok);
        end else if (st_q == ST_RUN && dual && partition_swap_instruction) begin
            p2_q <= !p2_q;                                        // see R16, R17
        end
    end

    // ------------------------------------------------------------
    // Flash port and fetch path
    // ------------------------------------------------------------
    // The loader owns flash until run; earlier fetches are dropped.
    always_ff @(posedge clk) begin
        if (rst) begin
            fl_rd_q   <= 1'b0;
            fl_addr_q <= 24'h000000;
        end else if (st_q != ST_RUN) begin
            fl_rd_q   <= (ph_q == 2'd0) && (st_q != ST_STRAP)
                      && (st_q != ST_PICK);
            if (ph_q == 2'd0) begin
                fl_addr_q <= boot_addr;
            end
        end else begin
            fl_rd_q <= fetch_req.req && f_impl && !f_deny;            // see R22
            if (fetch_req.req) begin
                fl_addr_q <= f_phys;
            end
        end
    end

    // Remember which half of the word was asked for and whether to blank.
    always_ff @(posedge clk) begin
        if (rst) begin
            pend_q <= 1'b0;
            odd_q  <= 1'b0;
            zero_q <= 1'b0;
            deny_q <= 1'b0;
        end else begin
            pend_q <= fetch_req.req && (st_q == ST_RUN);
            odd_q  <= fetch_req.addr[0];
            zero_q <= !f_impl || f_deny;
            deny_q <= f_impl && f_deny;
        end
    end

    // The upper word carries only bits 23:16; its high byte reads zero.
    always_ff @(posedge clk) begin
        if (rst) begin
            rsp_q <= '0;
        end else begin
            rsp_q.valid  <= pend_q;
            rsp_q.denied <= pend_q && deny_q;
            if (!pend_q || zero_q) begin
                rsp_q.data <= 16'h0000;                               // see R22
            end else if (odd_q) begin
                rsp_q.data <= {8'h00, fl_rdata[23:16]};               // see R1
            end else begin
                rsp_q.data <= fl_rdata[15:0];                         // see R1
            end
        end
    end

    // ------------------------------------------------------------
    // Program counter
    // ------------------------------------------------------------
    // Loads clear bit 0; a vector past its table's end is ignored.
    always_ff @(posedge clk) begin
        if (rst) begin
            pc_q <= RESET_ADDR;                                       // see R4
        end else if (st_q == ST_RUN) begin
            case (pc_op)
                PC_INC: begin
                    pc_q <= pc_q + 24'h000002;                        // see R2
                end
                PC_DEC: begin
                    pc_q <= pc_q - 24'h000002;                        // see R2
                end
                PC_LOAD: begin
                    pc_q <= {pc_target[23:1], 1'b0};                  // see R2
                end
                PC_VEC: begin
                    if (vec_addr <= vec_end) begin
                        pc_q <= {vec_addr[23:1], 1'b0};           // see R5, R6
                    end
                end
                default: begin
                    pc_q <= pc_q;
                end
            endcase
        end
    end

    // Flags the counter sitting inside the reserved vector area.
    always_ff @(posedge clk) begin
        if (rst) begin
            pc_in_vectors <= 1'b1;
        end else begin
            pc_in_vectors <= (pc_q <= VEC_RSV_END);                   // see R3
        end
    end

    // ------------------------------------------------------------
    // Register port
    // ------------------------------------------------------------
    // A base below the end of the reserved vector area is ignored.
    always_ff @(posedge clk) begin
        if (rst) begin
            aivt_base_q <= AIVT_RST;
            aivt_en_q   <= 1'b0;
        end else if (reg_wr) begin
            if (reg_addr == REG_AIVTB && reg_wdata >= VEC_RSV_END) begin
                aivt_base_q <= {reg_wdata[23:1], 1'b0};               // see R6
            end else if (reg_addr == REG_AIVTC) begin
                aivt_en_q <= reg_wdata[0];                            // see R6
            end
        end
    end

    // Sticky denial flag; a new denial beats a clear in the same cycle.
    always_ff @(posedge clk) begin
        if (rst) begin
            prot_err_q <= 1'b0;
        end else if (rsp_q.valid && rsp_q.denied) begin
            prot_err_q <= 1'b1;
        end else if (reg_wr && reg_addr == REG_STAT && reg_wdata[0]) begin
            prot_err_q <= 1'b0;
        end
    end

    // Read data stands for exactly one cycle; unmapped indices read zero.
    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_q <= 24'h000000;
        end else if (!reg_rd) begin
            rdata_q <= 24'h000000;
        end else if (reg_addr == REG_NVCTRL) begin
            rdata_q <= {12'h000, 1'b0, p2_q, 8'h00, mode_q};          // see R18
        end else if (reg_addr == REG_AIVTB) begin
            rdata_q <= aivt_base_q;
        end else if (reg_addr == REG_AIVTC) begin
            rdata_q <= {23'h0, aivt_en_q};
        end else if (reg_addr == REG_GEOM) begin
            rdata_q <= {ER_BLK_WORDS, WR_BLK_WORDS};                  // see R10
        end else if (reg_addr == REG_STAT) begin
            rdata_q <= {21'h0, st_q == ST_RUN, fallback_q, prot_err_q};
        end else if (reg_addr >= REG_CFG0 &&
                     reg_addr < REG_CFG0 + 5'(CFG_WORDS)) begin
            rdata_q <= cfg_q[4'(reg_addr - REG_CFG0)];
        end else begin
            rdata_q <= 24'h000000;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign fetch_rdy               = rdy_q;
    assign fetch_rsp               = rsp_q;
    assign pc                      = pc_q;
    assign fl_rd                   = fl_rd_q;
    assign fl_addr                 = fl_addr_q;
    assign cfg                     = cfg_q;
    assign second_partition_active = p2_q;                            // see R18
    assign reg_rdata               = rdata_q;

endmodule : dpm_program_map

// [tb/dpm_flash_model.sv]
// Combinational flash partner holding two physical partitions.
`timescale 1ns/1ns
module dpm_flash_model (
    input  wire logic        fl_rd,    // Read strobe.
    input  wire logic [23:0] fl_addr,  // Physical address.
    input  wire logic [23:0] seq1,     // Partition 1 boot word.
    input  wire logic [23:0] seq2,     // Partition 2 boot word.
    output logic      [23:0] fl_rdata  // Word read.
);
    import dpm_pkg::*;
    // An idle bus shows the inverted address, so stale data never passes as good.
    always_comb begin
        if (!fl_rd) begin
            fl_rdata = ~fl_addr;
        end else if (fl_addr[21:0] == 22'(DUAL_TOP - CFG_SPAN)) begin
            fl_rdata = fl_addr[22] ? seq2 : seq1;
        end else begin
            fl_rdata = {fl_addr[22] ? 8'h22 : 8'h11, fl_addr[15:0] ^ 16'h5A58};
        end
    end
endmodule : dpm_flash_model

// [tb/dpm_program_map_chk.sv]
// Concurrent checks on the program map's ports.
`timescale 1ns/1ns
module dpm_program_map_chk (
    input wire logic                    clk,
    input wire logic                    rst,
    input wire logic [1:0]              mode_strap,
    input wire dpm_pkg::dpm_fetch_req_s fetch_req,
    input wire logic                    fetch_rdy,
    input wire dpm_pkg::dpm_fetch_rsp_s fetch_rsp,
    input wire logic                    partition_swap_instruction,
    input wire dpm_pkg::dpm_pc_op_e     pc_op,
    input wire logic [23:0]             pc,
    input wire logic                    pc_in_vectors,
    input wire logic                    second_partition_active
);
    import dpm_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_fetch; fetch_req.req && fetch_rdy; endsequence
    sequence s_swap; partition_swap_instruction && fetch_rdy && mode_strap != 2'h0; endsequence
    a_fetch_answer: assert property (s_fetch |-> ##2 fetch_rsp.valid)
        else $error("fetch unanswered");
    a_odd_upper: assert property (s_fetch ##0 fetch_req.addr[0] |-> ##2 fetch_rsp.data[15:8] == 8'h00)
        else $error("upper byte not zero");
    a_pc_step: assert property (fetch_rdy && pc_op == PC_INC |=> pc == $past(pc) + 24'h000002)
        else $error("pc step wrong");
    a_start_addr: assert property (!fetch_rdy |-> pc == 24'h000000)
        else $error("pc left start");
    a_vec_flag: assert property (1'b1 |=> pc_in_vectors == ($past(pc) <= 24'h000200))
        else $error("vector flag wrong");
    a_swap_toggle: assert property (s_swap |=> second_partition_active != $past(second_partition_active))
        else $error("swap ignored");
    a_flag_steady: assert property (fetch_rdy && !partition_swap_instruction |=> $stable(second_partition_active))
        else $error("flag moved");
    a_single_mode: assert property (mode_strap == 2'h0 && fetch_rdy |-> !second_partition_active)
        else $error("single mode flag set");
endmodule : dpm_program_map_chk
bind dpm_program_map dpm_program_map_chk i_chk (.clk, .rst, .mode_strap, .fetch_req, .fetch_rdy,
    .fetch_rsp, .partition_swap_instruction, .pc_op, .pc, .pc_in_vectors, .second_partition_active);

// [tb/dual_partition_program_map_bench.sv]
// Self-checking bench for the dual-partition program map.
`timescale 1ns/1ns
module dual_partition_program_map_bench;
    import dpm_pkg::*;
    logic clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, partition_swap_instruction = 1'b0;
    logic fetch_rdy, pc_in_vectors, fl_rd, second_partition_active;
    logic [1:0] mode_strap = 2'h1;
    logic [4:0] reg_addr = 5'h00;
    logic [6:0] vec_num = 7'h00, ex = 7'h11;
    logic [23:0] pc_target = '0, reg_wdata = '0, seq1 = '0, seq2 = '0, pc, fl_addr, fl_rdata, reg_rdata;
    dpm_fetch_req_s fetch_req = '0;
    dpm_fetch_rsp_s fetch_rsp;
    dpm_pc_op_e pc_op = PC_HOLD;
    dpm_cfg_t cfg;
    int fail_count = 0, checks_done = 0;
    // Boot cases: strap and both boot words; ex holds the expected flags.
    logic [1:0] md [7] = '{2'h1, 2'h1, 2'h2, 2'h1, 2'h2, 2'h1, 2'h0};
    logic [23:0] w1 [7] = '{24'hFFA005, 24'hFFC003, 24'hFFB004, 24'h0, 24'h0, 24'hFF8007, 24'hFFA005};
    logic [23:0] w2 [7] = '{24'hFFC003, 24'hFFA005, 24'hFFB004, 24'h0, 24'hFF8007, 24'h0, 24'hFFC003};
    dpm_program_map i_dut (.clk, .rst, .mode_strap, .fetch_req, .fetch_rdy, .fetch_rsp,
        .partition_swap_instruction, .pc_op, .pc_target, .vec_num, .pc, .pc_in_vectors, .fl_rd,
        .fl_addr, .fl_rdata, .cfg, .second_partition_active, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata);
    dpm_flash_model i_flash (.fl_rd, .fl_addr, .seq1, .seq2, .fl_rdata);
    // A 10 ns clock.
    always #5 clk = ~clk;
    task automatic check(input string what, input logic [23:0] exp, got);
        checks_done++;
        if (got !== exp) begin
            $display("ERROR %s expected %h seen %h", what, exp, got);
            fail_count++;
        end
    endtask : check
    task automatic boot(input logic [1:0] m, input logic [23:0] a, b);
        @(posedge clk) {rst, mode_strap, seq1, seq2} <= {1'b1, m, a, b};
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 100 && fetch_rdy !== 1'b1; i++) @(negedge clk);
        check("ready", 24'h1, {23'h0, fetch_rdy});
    endtask : boot
    task automatic rw(input logic w, input logic [4:0] a, input logic [23:0] d);
        @(posedge clk) {reg_wr, reg_rd, reg_addr, reg_wdata} <= {w, !w, a, d};
        @(posedge clk);
        {reg_wr, reg_rd} <= 2'h0;
        #1 if (!w) check("register", d, reg_rdata);
    endtask : rw
    task automatic fetch(input logic [23:0] a, input logic [15:0] exp);
        @(posedge clk) fetch_req <= '{1'b1, a};
        @(posedge clk);
        fetch_req.req <= 1'b0;
        @(posedge clk);
        #1 check("fetch", {8'h02, exp}, {6'h00, fetch_rsp});
    endtask : fetch
    task automatic pcop(input dpm_pc_op_e op, input logic [23:0] exp);
        @(posedge clk) pc_op <= op;
        @(posedge clk);
        pc_op <= PC_HOLD;
        #1 check("pc", exp, pc);
    endtask : pcop
    task automatic results();
        $display("Checks made %0d, mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : results
    // Boot table, then map, swap, counter, vectors and registers.
    initial begin
        for (int k = 0; k < 7; k++) begin
            boot(md[k], w1[k], w2[k]);
            check("active", {23'h0, ex[k]}, {23'h0, second_partition_active});
        end
        boot(2'h1, 24'hFFA005, 24'hFFC003);
        check("config", 24'hFFC003, cfg[0]);
        rw(1'b0, REG_NVCTRL, 24'h000401);
        fetch(24'h000001, 16'h0022);
        fetch(24'h400001, 16'h0011);
        fetch(24'h000000, 16'h5A58);
        fetch(24'h015800, 16'h0000);
        @(posedge clk) partition_swap_instruction <= 1'b1;
        @(posedge clk);
        partition_swap_instruction <= 1'b0;
        #1 check("swap", 24'h0, {23'h0, second_partition_active});
        fetch(24'h000001, 16'h0011);
        boot(2'h1, 24'hFFA005, 24'hFFC003);
        check("reboot", 24'h1, {23'h0, second_partition_active});
        seq1 <= 24'hFFE001;
        pcop(PC_INC, 24'h000002);
        pcop(PC_INC, 24'h000004);
        pcop(PC_DEC, 24'h000002);
        check("kept", 24'h1, {23'h0, second_partition_active});
        @(posedge clk) pc_target <= 24'h000301;
        pcop(PC_LOAD, 24'h000300);
        @(posedge clk);
        #1 check("vector area", 24'h0, {23'h0, pc_in_vectors});
        rw(1'b0, REG_GEOM, 24'h200040);
        rw(1'b0, 5'h1F, 24'h000000);
        rw(1'b1, REG_AIVTB, 24'h000100);
        rw(1'b0, REG_AIVTB, 24'h000200);
        rw(1'b1, REG_AIVTB, 24'h000400);
        rw(1'b0, REG_AIVTB, 24'h000400);
        pcop(PC_VEC, 24'h000004);
        rw(1'b1, REG_AIVTC, 24'h000001);
        pcop(PC_VEC, 24'h000400);
        results();
    end
    // Watchdog: the sequence needs well under a thousand cycles.
    initial begin
        repeat (5000) @(posedge clk);
        fail_count++;
        results();
    end
endmodule : dual_partition_program_map_bench
